// *** design/dpm_pkg.sv ***
// Constants shared by the debug pin mode select block
package dpm_pkg;
    localparam int IR_W = 4;
    localparam int DR_W = 2;
    localparam int SYNC_N = 2;
    localparam logic [3:0] IR_RESET = 4'hF;
    localparam logic [3:0] IR_EMU_DIR = 4'h2;
    localparam logic [1:0] DIR_RESET = 2'h0;
    // Strap codes, bit 1 is emulation_pin_b, bit 0 is emulation_pin_a
    localparam logic [1:0] STRAP_BSCAN = 2'h1;
    localparam logic [1:0] STRAP_HOLD = 2'h2;
    localparam logic [1:0] SETTLE_CYC = 2'h2;
    typedef enum logic [0:0] {ST_SETTLE, ST_RUN} dpm_state_e;
endpackage

// *** design/dpm_scan_if.sv ***
// Carrier between the scan chain and the pin logic
`timescale 1ns/1ps
`default_nettype none
interface dpm_scan_if;
    logic [dpm_pkg::DR_W-1:0] emu_dir;
    logic                     tdo_bit;
    logic                     tdo_en;
    modport chain (output emu_dir, output tdo_bit, output tdo_en);
    modport pins  (input emu_dir, input tdo_bit, input tdo_en);
endinterface
`default_nettype wire

// *** design/dpm_scan_chain.sv ***
// Instruction and direction scan registers on the test clock
`timescale 1ns/1ps
`default_nettype none
module dpm_scan_chain #(
    parameter int IR_W = dpm_pkg::IR_W,
    parameter int DR_W = dpm_pkg::DR_W
) (
    input  wire logic   tck,
    input  wire logic   link_rst,
    input  wire logic   tdi,
    input  wire logic   shift_en,
    input  wire logic   sel_ir,
    input  wire logic   update,
    dpm_scan_if.chain   sc
);
    logic [IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic [DR_W-1:0] dr_sh_r, dr_sh_nxt, dir_r, dir_nxt;
    logic            byp_r, byp_nxt, tdo_r, tdo_nxt, tdo_en_r;

    // Shift in on the rising edge, update on the update strobe
    always_comb begin
        ir_sh_nxt = ir_sh_r;
        dr_sh_nxt = dr_sh_r;
        byp_nxt   = byp_r;
        ir_nxt    = ir_r;
        dir_nxt   = dir_r;
        if (shift_en && sel_ir) begin
            ir_sh_nxt = {tdi, ir_sh_r[IR_W-1:1]};
        end else if (shift_en && ir_r == dpm_pkg::IR_EMU_DIR) begin
            dr_sh_nxt = {tdi, dr_sh_r[DR_W-1:1]};
        end else if (shift_en) begin
            byp_nxt = tdi;
        end
        if (update && sel_ir) begin
            ir_nxt = ir_sh_r;
        end else if (update && ir_r == dpm_pkg::IR_EMU_DIR) begin
            dir_nxt = dr_sh_r;
        end
    end

    always_ff @(posedge tck or posedge link_rst) begin
        if (link_rst) begin
            ir_sh_r <= dpm_pkg::IR_RESET;
            ir_r    <= dpm_pkg::IR_RESET;
            dr_sh_r <= dpm_pkg::DIR_RESET;
            dir_r   <= dpm_pkg::DIR_RESET;
            byp_r   <= 1'b0;
        end else begin
            ir_sh_r <= ir_sh_nxt;
            ir_r    <= ir_nxt;
            dr_sh_r <= dr_sh_nxt;
            dir_r   <= dir_nxt;
            byp_r   <= byp_nxt;
        end
    end

    // Serial output picks the selected register's low bit
    always_comb begin
        if (sel_ir) begin
            tdo_nxt = ir_sh_r[0];
        end else if (ir_r == dpm_pkg::IR_EMU_DIR) begin
            tdo_nxt = dr_sh_r[0];
        end else begin
            tdo_nxt = byp_r;
        end
    end

    // Falling edge keeps half a period of hold for the probe
    always_ff @(negedge tck or posedge link_rst) begin
        if (link_rst) begin
            tdo_r    <= 1'b0;
            tdo_en_r <= 1'b0;
        end else begin
            tdo_r    <= tdo_nxt;
            tdo_en_r <= shift_en;
        end
    end

    assign sc.emu_dir = dir_r;
    assign sc.tdo_bit = tdo_r;
    assign sc.tdo_en  = tdo_en_r;

    chk_tdo_ir_out: assert property (
        @(negedge tck) disable iff (link_rst)
        sel_ir |=> tdo_r == $past(ir_sh_r[0]))
        else $error("serial output lost instruction bit");
    chk_ir_shift_in: assert property (
        @(posedge tck) disable iff (link_rst)
        (shift_en && sel_ir) |=> ir_sh_r[IR_W-1] == $past(tdi))
        else $error("input bit not taken on rising edge");
    chk_dir_update: assert property (
        @(posedge tck) disable iff (link_rst)
        (update && !sel_ir && ir_r == dpm_pkg::IR_EMU_DIR)
        |=> dir_r == $past(dr_sh_r))
        else $error("direction not loaded from scan");
    chk_dir_hold: assert property (
        @(posedge tck) disable iff (link_rst)
        !update |=> $stable(dir_r))
        else $error("direction changed without update");
endmodule // dpm_scan_chain
`default_nettype wire

// *** design/dpm_top.sv ***
// Emulation pin direction, scan output and strap mode latching
`timescale 1ns/1ps
`default_nettype none
module dpm_top (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       tck,
    input  wire logic       test_reset,
    input  wire logic       tdi,
    input  wire logic       scan_shift,
    input  wire logic       scan_sel_ir,
    input  wire logic       scan_update,
    input  wire logic       emulation_pin_a_in,
    output logic            emulation_pin_a_out,
    output logic            emulation_pin_a_oe,
    input  wire logic       emulation_pin_b_in,
    output logic            emulation_pin_b_out,
    output logic            emulation_pin_b_oe,
    output logic            tdo,
    output logic            tdo_oe,
    input  wire logic [1:0] dev_irq,
    output logic [1:0]      probe_irq,
    output logic            boundary_scan_mode,
    output logic            hold_boot_mode,
    output logic            boot_run
);
    localparam int SW = 5;

    dpm_scan_if sc ();

    logic link_rst;
    logic [1:0] irq_s1_r, irq_s2_r;
    logic [1:0] emu_out_r, emu_out_nxt, emu_oe_r, emu_oe_nxt;
    logic tdo_r, tdo_oe_r;
    logic [SW-1:0] s1_r, s2_r;
    logic trst_s, trst_d_r, trst_rise;
    logic [1:0] strap, dir_s;
    logic emu_a_s, emu_b_s;
    dpm_pkg::dpm_state_e state_r, state_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic bscan_r, bscan_nxt, hold_r, hold_nxt, run_r, run_nxt;
    logic [1:0] pirq_r, pirq_nxt;

    // Scan side sits in reset while test reset is low
    assign link_rst = reset | ~test_reset;

    dpm_scan_chain #(
        .IR_W (dpm_pkg::IR_W),
        .DR_W (dpm_pkg::DR_W)
    ) u_chain (
        .tck      (tck),
        .link_rst (link_rst),
        .tdi      (tdi),
        .shift_en (scan_shift),
        .sel_ir   (scan_sel_ir),
        .update   (scan_update),
        .sc       (sc.chain)
    );

    // Outgoing interrupt levels cross into the test clock domain
    always_ff @(posedge tck or posedge link_rst) begin
        if (link_rst) begin
            irq_s1_r <= 2'h0;
            irq_s2_r <= 2'h0;
        end else begin
            irq_s1_r <= dev_irq;
            irq_s2_r <= irq_s1_r;
        end
    end

    // Pins drive only where scan made them outputs
    always_comb begin
        emu_oe_nxt  = sc.emu_dir;
        emu_out_nxt = irq_s2_r;
    end

    // Async clear drops the drivers the moment test reset falls
    always_ff @(posedge tck or posedge link_rst) begin
        if (link_rst) begin
            emu_oe_r  <= 2'h0;
            emu_out_r <= 2'h0;
        end else begin
            emu_oe_r  <= emu_oe_nxt;
            emu_out_r <= emu_out_nxt;
        end
    end

    // Retimed on the falling edge, one fall behind the chain's output flop
    always_ff @(negedge tck or posedge link_rst) begin
        if (link_rst) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r    <= sc.tdo_bit;
            tdo_oe_r <= sc.tdo_en;
        end
    end

    // Pin and cross-domain levels pass two flops before use
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {sc.emu_dir, test_reset,
                     emulation_pin_b_in, emulation_pin_a_in};
            s2_r <= s1_r;
        end
    end

    assign emu_a_s = s2_r[0];
    assign emu_b_s = s2_r[1];
    assign trst_s  = s2_r[2];
    assign dir_s   = s2_r[4:3];
    assign strap   = {emu_b_s, emu_a_s};
    assign trst_rise = trst_s & ~trst_d_r;

    // Strap latching and boot gating
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        bscan_nxt = bscan_r;
        hold_nxt  = hold_r;
        run_nxt   = run_r;
        unique case (state_r)
            dpm_pkg::ST_SETTLE: begin
                // Wait for the synchronisers to hold real pin levels
                if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else begin
                    hold_nxt  = (strap == dpm_pkg::STRAP_HOLD);
                    run_nxt   = (strap != dpm_pkg::STRAP_HOLD);
                    state_nxt = dpm_pkg::ST_RUN;
                end
            end
            dpm_pkg::ST_RUN: begin
                run_nxt = ~hold_r;
            end
        endcase
        // Only a fresh test reset rise re-evaluates the scan mode
        if (trst_rise) begin
            bscan_nxt = (strap == dpm_pkg::STRAP_BSCAN);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r  <= dpm_pkg::ST_SETTLE;
            cnt_r    <= dpm_pkg::SETTLE_CYC;
            bscan_r  <= 1'b0;
            hold_r   <= 1'b0;
            run_r    <= 1'b0;
            trst_d_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            bscan_r  <= bscan_nxt;
            hold_r   <= hold_nxt;
            run_r    <= run_nxt;
            trst_d_r <= trst_s;
        end
    end

    // Incoming interrupts pass only on input pins while test reset is high
    always_comb begin
        pirq_nxt[0] = trst_s & ~dir_s[0] & emu_a_s;
        pirq_nxt[1] = trst_s & ~dir_s[1] & emu_b_s;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pirq_r <= 2'h0;
        end else begin
            pirq_r <= pirq_nxt;
        end
    end

    assign emulation_pin_a_out = emu_out_r[0];
    assign emulation_pin_a_oe  = emu_oe_r[0];
    assign emulation_pin_b_out = emu_out_r[1];
    assign emulation_pin_b_oe  = emu_oe_r[1];
    assign tdo                 = tdo_r;
    assign tdo_oe              = tdo_oe_r;
    assign probe_irq           = pirq_r;
    assign boundary_scan_mode  = bscan_r;
    assign hold_boot_mode      = hold_r;
    assign boot_run            = run_r;

    chk_oe_trst_low: assert property (
        @(posedge mclk) disable iff (reset)
        (!trst_s && !s1_r[2]) |-> !emulation_pin_a_oe && !emulation_pin_b_oe)
        else $error("emulation pin driven with test reset low");
    chk_oe_follows_dir: assert property (
        @(posedge tck) disable iff (link_rst)
        ##1 emu_oe_r == $past(sc.emu_dir))
        else $error("pin enable does not follow scan direction");
    chk_bscan_latch: assert property (
        @(posedge mclk) disable iff (reset)
        (trst_rise && strap == dpm_pkg::STRAP_BSCAN) |=> boundary_scan_mode)
        else $error("boundary-scan strap not latched");
    chk_bscan_hold: assert property (
        @(posedge mclk) disable iff (reset)
        !trst_rise |=> $stable(boundary_scan_mode))
        else $error("boundary-scan mode changed without test reset rise");
    chk_hold_boot_set: assert property (
        @(posedge mclk) disable iff (reset)
        (state_r == dpm_pkg::ST_SETTLE && cnt_r == 2'h0
         && strap == dpm_pkg::STRAP_HOLD) |=> hold_boot_mode [*3])
        else $error("hold boot strap not latched");
    chk_boot_blocked: assert property (
        @(posedge mclk) disable iff (reset)
        hold_boot_mode |-> !boot_run)
        else $error("boot loader runs in hold boot mode");
    chk_hold_stable: assert property (
        @(posedge mclk) disable iff (reset)
        state_r == dpm_pkg::ST_RUN |=> $stable(hold_boot_mode))
        else $error("hold boot mode changed after latch");
    chk_probe_irq_in: assert property (
        @(posedge mclk) disable iff (reset)
        (trst_s && !dir_s[0]) |=> probe_irq[0] == $past(emu_a_s))
        else $error("incoming interrupt on pin a not passed");
endmodule // dpm_top
`default_nettype wire

// *** dv/dpm_probe.sv ***
// Debug probe model: test clock, scan frames and pin pulls
`timescale 1ns/1ps
`default_nettype none
module dpm_probe (
    output logic            tck,
    output logic            test_reset,
    output logic            tdi,
    output logic            scan_shift,
    output logic            scan_sel_ir,
    output logic            scan_update,
    input  wire logic       tdo,
    input  wire logic       tdo_oe,
    input  wire logic [1:0] dev_out,
    input  wire logic [1:0] dev_oe,
    input  wire logic [1:0] pdrv,
    input  wire logic [1:0] pen,
    output logic [1:0]      lvl
);
    // Pull-ups win when nobody drives a pin
    assign lvl[0] = dev_oe[0] ? dev_out[0] : (pen[0] ? pdrv[0] : 1'b1);
    assign lvl[1] = dev_oe[1] ? dev_out[1] : (pen[1] ? pdrv[1] : 1'b1);

    // Test clock only runs inside pulse, called by frames, test reset rises and the bench
    initial begin
        tck = 1'b0;
        test_reset = 1'b0;
        tdi = 1'b1;
        scan_shift = 1'b0;
        scan_sel_ir = 1'b0;
        scan_update = 1'b0;
    end

    // One test clock period, ending just after the fall
    task automatic pulse();
        #6 tck = 1'b1;
        #5 tck = 1'b0;
        #1;
    endtask

    // Two idle rises before the first request
    task automatic trst(input logic v);
        // Step off the system clock edge so the synchroniser sees no race
        #1;
        test_reset = v;
        if (v) begin
            pulse();
            pulse();
        end
    endtask

    // Shift LSB first, then update; serial output seen after each fall
    task automatic frame(input logic sel, input logic [7:0] v, input int n,
                         output logic [7:0] got, output logic [7:0] goe);
        got = 8'h00;
        goe = 8'h00;
        for (int i = 0; i < n; i++) begin
            scan_shift = 1'b1;
            scan_sel_ir = sel;
            tdi = v[i];
            pulse();
            got[i] = tdo;
            goe[i] = tdo_oe;
        end
        scan_shift = 1'b0;
        tdi = 1'b1;
        scan_update = 1'b1;
        pulse();
        scan_update = 1'b0;
    endtask
endmodule // dpm_probe
`default_nettype wire

// *** dv/dpm_top_test.sv ***
// Self-checking bench for the debug pin mode select block
`timescale 1ns/1ps
`default_nettype none
module dpm_top_test;
    logic       mclk, reset, tck, test_reset, tdi, scan_shift;
    logic       scan_sel_ir, scan_update, tdo, tdo_oe;
    logic       out_a, out_b, oe_a, oe_b, bscan, hold, boot_run;
    logic [1:0] dev_irq, probe_irq, pdrv, pen, lvl;
    logic [7:0] v, got, goe;
    logic [31:0] seed = 32'h00000022;
    int         num_errors = 0;
    int         n_compared = 0;

    dpm_top u_dut (.mclk(mclk), .reset(reset), .tck(tck),
        .test_reset(test_reset), .tdi(tdi), .scan_shift(scan_shift),
        .scan_sel_ir(scan_sel_ir), .scan_update(scan_update),
        .emulation_pin_a_in(lvl[0]), .emulation_pin_a_out(out_a),
        .emulation_pin_a_oe(oe_a), .emulation_pin_b_in(lvl[1]),
        .emulation_pin_b_out(out_b), .emulation_pin_b_oe(oe_b),
        .tdo(tdo), .tdo_oe(tdo_oe), .dev_irq(dev_irq),
        .probe_irq(probe_irq), .boundary_scan_mode(bscan),
        .hold_boot_mode(hold), .boot_run(boot_run));

    dpm_probe u_probe (.tck(tck), .test_reset(test_reset), .tdi(tdi),
        .scan_shift(scan_shift), .scan_sel_ir(scan_sel_ir),
        .scan_update(scan_update), .tdo(tdo), .tdo_oe(tdo_oe),
        .dev_out({out_b, out_a}), .dev_oe({oe_b, oe_a}), .pdrv(pdrv),
        .pen(pen), .lvl(lvl));

    // System clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Xorshift keeps the random run repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected strap and interrupt results
    function automatic logic exp_bscan(input logic [1:0] c);
        return c == dpm_pkg::STRAP_BSCAN;
    endfunction
    function automatic logic [1:0] exp_irq(input logic [1:0] d, p);
        return ~d & p;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic compare(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Strap at system reset exit, pins stable well before release
    task automatic sys_reset(input logic [1:0] strap);
        @(posedge mclk);
        pdrv <= strap;
        reset <= 1'b1;
        cyc(6);
        reset <= 1'b0;
        cyc(8);
    endtask

    // Hang guard
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        dev_irq = 2'h0;
        pdrv = 2'h0;
        pen = 2'h3;
        sys_reset(dpm_pkg::STRAP_HOLD);
        compare({hold, boot_run}, 8'h02);
        pdrv <= 2'h3;
        cyc(8);
        compare({hold, boot_run}, 8'h02);
        sys_reset(2'h3);
        compare({hold, boot_run}, 8'h01);
        // Every strap code on a test reset rise, then pins wander
        for (int c = 0; c < 4; c++) begin
            u_probe.trst(1'b0);
            pdrv <= c[1:0];
            cyc(4);
            compare({probe_irq, oe_b, oe_a}, 8'h00);
            u_probe.trst(1'b1);
            cyc(6);
            compare(bscan, exp_bscan(c[1:0]));
            seed = xs(seed);
            pdrv <= seed[1:0];
            cyc(6);
            compare(bscan, exp_bscan(c[1:0]));
        end
        // Bypass path: serial output trails input by one bit
        seed = xs(seed);
        v = seed[7:0];
        u_probe.frame(1'b0, v, 8, got, goe);
        compare(got[7:1], v[6:0]);
        // Enable lags one fall behind shift, like the data bit
        compare(goe, 8'hFE);
        // Each direction code, random interrupt levels both ways
        for (int d = 0; d < 4; d++) begin
            u_probe.frame(1'b1, 8'h02, 4, got, goe);
            u_probe.frame(1'b0, d, 2, got, goe);
            seed = xs(seed);
            @(posedge mclk);
            dev_irq <= seed[1:0];
            pdrv <= seed[3:2];
            cyc(4);
            u_probe.pulse();
            u_probe.pulse();
            u_probe.pulse();
            cyc(6);
            compare({oe_b, oe_a}, d);
            compare({out_b, out_a}, seed[1:0]);
            compare(probe_irq, exp_irq(d, seed[3:2]));
        end
        u_probe.trst(1'b0);
        cyc(6);
        compare({probe_irq, oe_b, oe_a}, 8'h00);
        summarize();
    end
endmodule // dpm_top_test
`default_nettype wire
